// ===== sps_pkg.sv
// Constants, register map and types for the serial port status block
// Contract
// - Error sets flag and loads error code
// - Error flags clear only by power cycle
// - Send request starts frame transmission
// - Receive complete set when frame ends
// - No reception while receive complete set
// - Carrier flag follows DCD on ch1, ch2
// - DSR flag follows DSR on ch1, ch2
// - Time-out flag when bytes stop too long
// - Send-wait high while sending held off
// - Full duplex: DSR low pauses send
// - Half duplex: defer send during reception
// - Read-only count of bytes left to send
// - Read-only count of bytes received
// - Two header and two terminator words
// - Keep received, computed and sent sums
// - Read-only operation mode code word
// - Time-out in 10 ms units, zero 100 ms
// - Send request clears when frame sent
// - Reception ends on count, terminator, time-out
// - Clearing receive complete re-arms reception
package sps_pkg;
  localparam int         NCH        = 3;
  localparam int         TW         = 20;
  localparam int         CLK_MHZ    = 100;
  localparam int         TO_UNIT_MS = 10;
  localparam int         TO_ZERO_MS = 100;
  localparam int         TICK_CYC_DEF = TO_UNIT_MS * 1000 * CLK_MHZ;
  localparam logic [7:0] TO_ZERO_TICKS = 8'(TO_ZERO_MS / TO_UNIT_MS);
  // Word index within a channel window, channel in paddr[7:6]
  localparam logic [3:0] REG_FLAGS  = 4'h0;
  localparam logic [3:0] REG_ECODE  = 4'h1;
  localparam logic [3:0] REG_FMT    = 4'h2;
  localparam logic [3:0] REG_REM    = 4'h3;
  localparam logic [3:0] REG_RCNT   = 4'h4;
  localparam logic [3:0] REG_PARAM  = 4'h5;
  localparam logic [3:0] REG_TO     = 4'h6;
  localparam logic [3:0] REG_HDR_A  = 4'h7;
  localparam logic [3:0] REG_HDR_B  = 4'h8;
  localparam logic [3:0] REG_TRM_A  = 4'h9;
  localparam logic [3:0] REG_TRM_B  = 4'ha;
  localparam logic [3:0] REG_SRX    = 4'hb;
  localparam logic [3:0] REG_SCAL   = 4'hc;
  localparam logic [3:0] REG_STX    = 4'hd;
  localparam logic [3:0] REG_MODE   = 4'he;
  localparam logic [3:0] REG_LEN    = 4'hf;
  localparam logic [1:0] CH_NONE    = 2'h3;
  localparam int         FB_ERR = 0;
  localparam int         FB_WAIT = 1;
  localparam int         FB_SREQ = 2;
  localparam int         FB_RCMP = 3;
  localparam int         FB_CD = 4;
  localparam int         FB_DSR = 5;
  localparam int         FB_TOUT = 6;
  localparam int         FMT_HALF = 0;
  localparam int         FMT_HDR = 1;
  localparam int         FMT_TRM = 2;
  localparam int         FMT_SUM = 3;
  localparam int         FMT_CTL_LO = 10;
  localparam int         FMT_CTL_HI = 11;
  localparam logic [1:0] CTL_STD    = 2'h1;
  localparam logic [1:0] CTL_ILK    = 2'h2;
  localparam logic [15:0] FMT_RST   = 16'h0000;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [15:0] MODE_CODE = 16'h0005;
  typedef enum logic [2:0] {TX_IDLE, TX_HDR, TX_DATA, TX_SUM, TX_TRM} sps_tx_t;
endpackage

// ===== sps_top.sv
// Three-channel serial transfer status, control and count block
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module sps_top #(
  parameter int TICK_CYC = sps_pkg::TICK_CYC_DEF  // Cycles per time-out unit
) (
  input  wire logic        clk,       // System clock
  input  wire logic        arst_n,    // Power-on reset
  input  wire logic        ce,        // Clock enable
  input  wire logic [7:0]  paddr,     // APB address
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB enable
  input  wire logic        pwrite,    // APB write
  input  wire logic [31:0] pwdata,    // APB write data
  output logic      [31:0] prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr,   // APB error
  input  wire logic [2:0]  rx_valid,  // Received byte strobe
  input  wire logic [23:0] rx_data,   // Received bytes
  input  wire logic [2:0]  err_evt,   // Line error strobe
  input  wire logic [47:0] err_code,  // Error code per channel
  input  wire logic [2:0]  dcd,       // Carrier detect level
  input  wire logic [2:0]  dsr,       // Data set ready level
  output logic      [2:0]  tx_valid,  // Send byte valid
  input  wire logic [2:0]  tx_ready,  // Serializer takes byte
  output logic      [23:0] tx_data,   // Send bytes
  output logic      [23:0] pay_idx,   // Payload index wanted
  input  wire logic [23:0] pay_data   // Payload byte at pay_idx
);
  localparam int N = sps_pkg::NCH;
  logic [1:0]  rs_reg;
  logic        rst_n;
  logic [15:0] fmt_reg[N], to_reg[N], len_reg[N], hdr_a_reg[N], hdr_b_reg[N];
  logic [15:0] trm_a_reg[N], trm_b_reg[N], ecode_reg[N], rem_reg[N];
  logic [15:0] rcnt_reg[N], srx_reg[N], scal_reg[N], stx_reg[N];
  logic [N-1:0] err_reg, sreq_reg, rcmp_reg, tout_reg, cd_reg, dsr_reg;
  logic [N-1:0] hdr_ok_reg, sumw_reg, wait_w, fire, rx_ok, rx_act;
  logic [7:0]  tx_d_reg[N], ptr_reg[N], tcnt_reg[N];
  sps_pkg::sps_tx_t st_reg[N];
  logic [sps_pkg::TW-1:0] tick_reg;
  logic        tick, rdy_reg, wr;
  logic [1:0]  wch;
  logic [3:0]  widx;
  logic [15:0] rd_w;

  function automatic logic whit(input int c, input logic [3:0] i);
    return wr && (wch == 2'(c)) && (widx == i);
  endfunction

  function automatic logic [7:0] to_lim(input logic [15:0] s);
    return (s[7:0] == 8'h00) ? sps_pkg::TO_ZERO_TICKS : s[7:0];
  endfunction

  function automatic sps_pkg::sps_tx_t after_data(input logic [15:0] f);
    if (f[sps_pkg::FMT_SUM]) return sps_pkg::TX_SUM;
    if (f[sps_pkg::FMT_TRM]) return sps_pkg::TX_TRM;
    return sps_pkg::TX_IDLE;
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rs_reg <= 2'h0;
    else rs_reg <= {rs_reg[0], 1'b1};
  end
  assign rst_n = rs_reg[1];

  // APB slave, one wait state so read data comes from a flop
  assign wch = paddr[7:6];
  assign widx = paddr[5:2];
  assign wr = psel && penable && pwrite && rdy_reg && ce;
  assign pready = rdy_reg;

  always_comb begin
    rd_w = sps_pkg::WORD_RST;
    if (wch != sps_pkg::CH_NONE) begin
      case (widx)
        sps_pkg::REG_FLAGS: begin
          rd_w[sps_pkg::FB_ERR] = err_reg[wch];
          rd_w[sps_pkg::FB_WAIT] = wait_w[wch];
          rd_w[sps_pkg::FB_SREQ] = sreq_reg[wch];
          rd_w[sps_pkg::FB_RCMP] = rcmp_reg[wch];
          rd_w[sps_pkg::FB_CD] = cd_reg[wch];
          rd_w[sps_pkg::FB_DSR] = dsr_reg[wch];
          rd_w[sps_pkg::FB_TOUT] = tout_reg[wch];
        end
        sps_pkg::REG_ECODE: rd_w = ecode_reg[wch];
        sps_pkg::REG_FMT:   rd_w = fmt_reg[wch];
        sps_pkg::REG_REM:   rd_w = rem_reg[wch];
        sps_pkg::REG_RCNT:  rd_w = rcnt_reg[wch];
        sps_pkg::REG_PARAM: rd_w = sps_pkg::FMT_RST;
        sps_pkg::REG_TO:    rd_w = to_reg[wch];
        sps_pkg::REG_HDR_A: rd_w = hdr_a_reg[wch];
        sps_pkg::REG_HDR_B: rd_w = hdr_b_reg[wch];
        sps_pkg::REG_TRM_A: rd_w = trm_a_reg[wch];
        sps_pkg::REG_TRM_B: rd_w = trm_b_reg[wch];
        sps_pkg::REG_SRX:   rd_w = srx_reg[wch];
        sps_pkg::REG_SCAL:  rd_w = scal_reg[wch];
        sps_pkg::REG_STX:   rd_w = stx_reg[wch];
        sps_pkg::REG_MODE:  rd_w = sps_pkg::MODE_CODE;
        sps_pkg::REG_LEN:   rd_w = len_reg[wch];
        default:            rd_w = sps_pkg::WORD_RST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_reg <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      rdy_reg <= psel && penable && !rdy_reg;
      if (psel && penable && !rdy_reg) begin
        prdata <= {16'h0000, rd_w};
        pslverr <= (wch == sps_pkg::CH_NONE);
      end
    end
  end

  // Configuration words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < N; c++) begin
        fmt_reg[c] <= sps_pkg::FMT_RST;
        to_reg[c] <= sps_pkg::WORD_RST;
        len_reg[c] <= sps_pkg::WORD_RST;
        hdr_a_reg[c] <= sps_pkg::WORD_RST;
        hdr_b_reg[c] <= sps_pkg::WORD_RST;
        trm_a_reg[c] <= sps_pkg::WORD_RST;
        trm_b_reg[c] <= sps_pkg::WORD_RST;
      end
    end else if (ce) begin
      for (int c = 0; c < N; c++) begin
        if (whit(c, sps_pkg::REG_FMT)) fmt_reg[c] <= pwdata[15:0];
        if (whit(c, sps_pkg::REG_TO)) to_reg[c] <= pwdata[15:0];
        if (whit(c, sps_pkg::REG_LEN)) len_reg[c] <= pwdata[15:0];
        if (whit(c, sps_pkg::REG_HDR_A)) hdr_a_reg[c] <= pwdata[15:0];
        if (whit(c, sps_pkg::REG_HDR_B)) hdr_b_reg[c] <= pwdata[15:0];
        if (whit(c, sps_pkg::REG_TRM_A)) trm_a_reg[c] <= pwdata[15:0];
        if (whit(c, sps_pkg::REG_TRM_B)) trm_b_reg[c] <= pwdata[15:0];
      end
    end
  end

  // Error flags, line status images
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg <= '0;
      cd_reg <= '0;
      dsr_reg <= '0;
      for (int c = 0; c < N; c++) ecode_reg[c] <= sps_pkg::WORD_RST;
    end else if (ce) begin
      for (int c = 0; c < N; c++) begin
        if (err_evt[c]) begin
          err_reg[c] <= 1'b1;
          ecode_reg[c] <= err_code[c*16 +: 16];
        end
        cd_reg[c] <= (c != 0) && dcd[c];
        dsr_reg[c] <= (c != 0) && dsr[c];
      end
    end
  end

  // Hold-off and handshake terms
  always_comb begin
    for (int c = 0; c < N; c++) begin
      rx_act[c] = !rcmp_reg[c] && (rcnt_reg[c] != 16'h0000 || sumw_reg[c]
                  || (hdr_ok_reg[c] && fmt_reg[c][sps_pkg::FMT_HDR]));
      if (fmt_reg[c][sps_pkg::FMT_HALF])
        wait_w[c] = sreq_reg[c] && st_reg[c] == sps_pkg::TX_IDLE && rx_act[c];
      else
        wait_w[c] = sreq_reg[c] && st_reg[c] != sps_pkg::TX_IDLE && (c != 0)
                    && !dsr_reg[c]
                    && (fmt_reg[c][sps_pkg::FMT_CTL_HI:sps_pkg::FMT_CTL_LO] == sps_pkg::CTL_STD
                    || fmt_reg[c][sps_pkg::FMT_CTL_HI:sps_pkg::FMT_CTL_LO] == sps_pkg::CTL_ILK);
      tx_valid[c] = st_reg[c] != sps_pkg::TX_IDLE && !wait_w[c];
      fire[c] = tx_valid[c] && tx_ready[c];
      tx_data[c*8 +: 8] = tx_d_reg[c];
      pay_idx[c*8 +: 8] = (st_reg[c] == sps_pkg::TX_DATA) ? ptr_reg[c] + 8'h01 : 8'h00;
      rx_ok[c] = rx_valid[c] && !rcmp_reg[c] && len_reg[c][15:8] != 8'h00;
    end
  end

  assign tick = tick_reg == sps_pkg::TW'(TICK_CYC - 1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tick_reg <= '0;
    else if (ce) tick_reg <= tick ? '0 : tick_reg + 1'b1;
  end

  // Step to sum, terminator or end after the last payload byte
  task automatic tx_after(input int c, input logic [7:0] s);
    st_reg[c] <= after_data(fmt_reg[c]);
    tx_d_reg[c] <= fmt_reg[c][sps_pkg::FMT_SUM] ? s : trm_a_reg[c][7:0];
    if (after_data(fmt_reg[c]) == sps_pkg::TX_IDLE) sreq_reg[c] <= 1'b0;
  endtask

  // Transmit sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sreq_reg <= '0;
      for (int c = 0; c < N; c++) begin
        st_reg[c] <= sps_pkg::TX_IDLE;
        tx_d_reg[c] <= 8'h00;
        ptr_reg[c] <= 8'h00;
        rem_reg[c] <= sps_pkg::WORD_RST;
        stx_reg[c] <= sps_pkg::WORD_RST;
      end
    end else if (ce) begin
      for (int c = 0; c < N; c++) begin
        if (whit(c, sps_pkg::REG_FLAGS)) sreq_reg[c] <= pwdata[sps_pkg::FB_SREQ];
        if (st_reg[c] == sps_pkg::TX_IDLE) begin
          if (sreq_reg[c] && !wait_w[c]) begin
            ptr_reg[c] <= 8'h00;
            stx_reg[c] <= sps_pkg::WORD_RST;
            rem_reg[c] <= 16'(len_reg[c][7:0]) + 16'(fmt_reg[c][sps_pkg::FMT_HDR])
                          + 16'(fmt_reg[c][sps_pkg::FMT_SUM])
                          + 16'(fmt_reg[c][sps_pkg::FMT_TRM]);
            if (fmt_reg[c][sps_pkg::FMT_HDR]) begin
              st_reg[c] <= sps_pkg::TX_HDR;
              tx_d_reg[c] <= hdr_a_reg[c][7:0];
            end else if (len_reg[c][7:0] != 8'h00) begin
              st_reg[c] <= sps_pkg::TX_DATA;
              tx_d_reg[c] <= pay_data[c*8 +: 8];
            end else begin
              tx_after(c, 8'h00);
            end
          end
        end else if (fire[c]) begin
          rem_reg[c] <= rem_reg[c] - 16'h0001;
          case (st_reg[c])
            sps_pkg::TX_HDR: begin
              if (len_reg[c][7:0] != 8'h00) begin
                st_reg[c] <= sps_pkg::TX_DATA;
                tx_d_reg[c] <= pay_data[c*8 +: 8];
              end else begin
                tx_after(c, 8'h00);
              end
            end
            sps_pkg::TX_DATA: begin
              stx_reg[c] <= stx_reg[c] + 16'(tx_d_reg[c]);
              ptr_reg[c] <= ptr_reg[c] + 8'h01;
              if ((ptr_reg[c] + 8'h01) < len_reg[c][7:0]) tx_d_reg[c] <= pay_data[c*8 +: 8];
              else tx_after(c, stx_reg[c][7:0] + tx_d_reg[c]);
            end
            sps_pkg::TX_SUM: begin
              if (fmt_reg[c][sps_pkg::FMT_TRM]) begin
                st_reg[c] <= sps_pkg::TX_TRM;
                tx_d_reg[c] <= trm_a_reg[c][7:0];
              end else begin
                st_reg[c] <= sps_pkg::TX_IDLE;
                sreq_reg[c] <= 1'b0;
              end
            end
            default: begin
              st_reg[c] <= sps_pkg::TX_IDLE;
              sreq_reg[c] <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Receive framing, completion and time-out; hardware set beats software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcmp_reg <= '0;
      tout_reg <= '0;
      hdr_ok_reg <= '0;
      sumw_reg <= '0;
      for (int c = 0; c < N; c++) begin
        rcnt_reg[c] <= sps_pkg::WORD_RST;
        srx_reg[c] <= sps_pkg::WORD_RST;
        scal_reg[c] <= sps_pkg::WORD_RST;
        tcnt_reg[c] <= 8'h00;
      end
    end else if (ce) begin
      for (int c = 0; c < N; c++) begin
        if (whit(c, sps_pkg::REG_FLAGS)) begin
          if (rcmp_reg[c] && !pwdata[sps_pkg::FB_RCMP]) begin
            rcmp_reg[c] <= 1'b0;
            rcnt_reg[c] <= sps_pkg::WORD_RST;
            hdr_ok_reg[c] <= 1'b0;
            sumw_reg[c] <= 1'b0;
            tout_reg[c] <= 1'b0;
            tcnt_reg[c] <= 8'h00;
          end
          if (!pwdata[sps_pkg::FB_TOUT]) tout_reg[c] <= 1'b0;
        end
        if (rx_ok[c]) begin
          tcnt_reg[c] <= 8'h00;
          if (sumw_reg[c]) begin
            srx_reg[c] <= 16'(rx_data[c*8 +: 8]);
            sumw_reg[c] <= 1'b0;
            rcmp_reg[c] <= 1'b1;
          end else if (!hdr_ok_reg[c] && fmt_reg[c][sps_pkg::FMT_HDR]) begin
            hdr_ok_reg[c] <= rx_data[c*8 +: 8] == hdr_a_reg[c][7:0];
          end else begin
            rcnt_reg[c] <= rcnt_reg[c] + 16'h0001;
            scal_reg[c] <= (rcnt_reg[c] == 16'h0000 ? sps_pkg::WORD_RST : scal_reg[c])
                           + 16'(rx_data[c*8 +: 8]);
            if (rcnt_reg[c] + 16'h0001 == 16'(len_reg[c][15:8])
                || (fmt_reg[c][sps_pkg::FMT_TRM]
                && rx_data[c*8 +: 8] == trm_a_reg[c][7:0])) begin
              if (fmt_reg[c][sps_pkg::FMT_SUM]) sumw_reg[c] <= 1'b1;
              else rcmp_reg[c] <= 1'b1;
            end
          end
        end else if (rx_act[c] && tick) begin
          if (tcnt_reg[c] >= to_lim(to_reg[c]) - 8'h01) begin
            tout_reg[c] <= 1'b1;
            rcmp_reg[c] <= 1'b1;
          end else begin
            tcnt_reg[c] <= tcnt_reg[c] + 8'h01;
          end
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  for (genvar g = 0; g < N; g++) begin : g_chk
    property p_err_load;
      ce && err_evt[g] |=> err_reg[g] && ecode_reg[g] == $past(err_code[g*16 +: 16]);
    endproperty
    a_err_load: assert property (p_err_load) else $error("error code not loaded");
    property p_err_hold;
      err_reg[g] |=> err_reg[g];
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag cleared");
    property p_start;
      ce && st_reg[g] == sps_pkg::TX_IDLE && sreq_reg[g] && !wait_w[g]
        |=> st_reg[g] != sps_pkg::TX_IDLE || !sreq_reg[g];
    endproperty
    a_start: assert property (p_start) else $error("send did not start");
    property p_rx_block;
      rcmp_reg[g] |=> $stable(rcnt_reg[g]) || rcnt_reg[g] == 16'h0000;
    endproperty
    a_rx_block: assert property (p_rx_block) else $error("byte taken when complete");
    property p_cd;
      ce |=> cd_reg[g] == ((g != 0) && $past(dcd[g]));
    endproperty
    a_cd: assert property (p_cd) else $error("carrier flag wrong");
    property p_dsr;
      ce |=> dsr_reg[g] == ((g != 0) && $past(dsr[g]));
    endproperty
    a_dsr: assert property (p_dsr) else $error("dsr flag wrong");
    property p_dsr_wait;
      sreq_reg[g] && st_reg[g] != sps_pkg::TX_IDLE && !fmt_reg[g][sps_pkg::FMT_HALF]
        && (g != 0) && !dsr_reg[g]
        && (fmt_reg[g][sps_pkg::FMT_CTL_HI:sps_pkg::FMT_CTL_LO] == sps_pkg::CTL_STD
        || fmt_reg[g][sps_pkg::FMT_CTL_HI:sps_pkg::FMT_CTL_LO] == sps_pkg::CTL_ILK)
        |-> wait_w[g] && !tx_valid[g];
    endproperty
    a_dsr_wait: assert property (p_dsr_wait) else $error("send not paused");
    property p_rem;
      ce && fire[g] |=> rem_reg[g] == $past(rem_reg[g]) - 16'h0001;
    endproperty
    a_rem: assert property (p_rem) else $error("send count wrong");
    property p_done;
      ce && fire[g] && rem_reg[g] == 16'h0001 |=> st_reg[g] == sps_pkg::TX_IDLE && !sreq_reg[g];
    endproperty
    a_done: assert property (p_done) else $error("request not cleared");
    property p_tout;
      $rose(tout_reg[g]) |-> rcmp_reg[g] && $past(tick);
    endproperty
    a_tout: assert property (p_tout) else $error("time-out without complete");
    c_tx: cover property (ce && fire[g] && rem_reg[g] == 16'h0001);
    c_rx: cover property ($rose(rcmp_reg[g]) && !tout_reg[g]);
    c_to: cover property ($rose(tout_reg[g]));
    c_wait: cover property (wait_w[g] && sreq_reg[g]);
  end
endmodule // sps_top

// ===== sps_far_end.sv
// Far-end serializer model and payload store for the serial port block
`timescale 1ns/1ps
module sps_far_end (
  input  wire logic        clk,       // System clock
  input  wire logic        slow,      // Stall every other cycle
  input  wire logic [2:0]  tx_valid,  // Send byte valid
  input  wire logic [23:0] tx_data,   // Send bytes
  output logic      [2:0]  tx_ready,  // Byte taken
  input  wire logic [23:0] pay_idx,   // Payload index wanted
  output logic      [23:0] pay_data   // Payload byte
);
  logic [9:0] sent_q [$];
  logic       phase_reg;
  initial begin
    tx_ready  = 3'h0;
    phase_reg = 1'b0;
  end
  // Payload byte is its index plus an offset
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      pay_data[c*8+:8] = pay_idx[c*8+:8] + 8'h30;
    end
  end
  always @(posedge clk) begin
    for (int c = 0; c < 3; c++) begin
      if (tx_valid[c] && tx_ready[c]) begin
        sent_q.push_back({2'(c), tx_data[c*8+:8]});
      end
    end
    phase_reg <= ~phase_reg;
    tx_ready  <= (slow && phase_reg) ? 3'h0 : 3'h7;
  end
endmodule // sps_far_end

// ===== sps_top_bench.sv
// Self-checking bench for the serial port status block
`timescale 1ns/1ps
module sps_top_bench;
  localparam int TICK = 20;
  logic        clk = 0, arst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, err_q;
  logic [2:0]  rx_valid = 0, err_evt = 0, dcd = 0, dsr = 0, tx_valid, tx_ready;
  logic [23:0] rx_data = 0, tx_data, pay_idx, pay_data;
  logic [47:0] err_code = 0;
  logic [15:0] rd_q;
  logic [7:0]  exp_b [6] = '{8'ha5, 8'h30, 8'h31, 8'h32, 8'h93, 8'h0d};
  int          fail_count = 0, checks = 0, cyc = 0;
  always #5 clk = ~clk;
  sps_top #(.TICK_CYC(TICK)) dut (.clk(clk), .arst_n(arst_n), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .err_evt(err_evt), .err_code(err_code), .dcd(dcd), .dsr(dsr), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .pay_idx(pay_idx), .pay_data(pay_data));
  sps_far_end far (.clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .pay_idx(pay_idx), .pay_data(pay_data));
  function automatic logic [15:0] fb(input int b);
    return 16'h0001 << b;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [1:0] ch, input logic [3:0] idx, input logic w,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    paddr  <= {ch, idx, 2'b00};
    pwrite <= w;
    pwdata <= {16'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_q = prdata[15:0];
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [1:0] ch, input logic [3:0] idx, input logic [15:0] d);
    apb(ch, idx, 1'b1, d);
  endtask
  task automatic rdc(input logic [1:0] ch, input logic [3:0] idx, input logic [15:0] m,
                     input logic [15:0] e);
    apb(ch, idx, 1'b0, 16'h0);
    check({16'h0, rd_q & m}, {16'h0, e});
  endtask
  task automatic rxb(input int ch, input logic [7:0] b);
    @(posedge clk);
    rx_valid[ch] <= 1'b1;
    rx_data[ch*8+:8] <= b;
    @(posedge clk);
    rx_valid[ch] <= 1'b0;
  endtask
  task automatic wait_sent(input int n);
    for (int i = 0; i < 300 && far.sent_q.size() < n; i++) @(posedge clk);
  endtask
  task automatic t_regs;
    rdc(1, sps_pkg::REG_FLAGS, 16'hffff, 16'h0000);
    rdc(1, sps_pkg::REG_MODE, 16'hffff, sps_pkg::MODE_CODE);
    rdc(1, sps_pkg::REG_PARAM, 16'hffff, sps_pkg::FMT_RST);
    wr(1, sps_pkg::REG_HDR_B, 16'hbeef);
    rdc(1, sps_pkg::REG_HDR_B, 16'hffff, 16'hbeef);
    wr(1, sps_pkg::REG_REM, 16'h00ff);
    rdc(1, sps_pkg::REG_REM, 16'hffff, 16'h0000);
    apb(2'h3, sps_pkg::REG_MODE, 1'b0, 16'h0);
    check({rd_q, 15'h0, err_q}, 32'h0000_0001);
  endtask
  task automatic t_err;
    err_code[31:16] <= 16'h1234;
    // Clock enable low drops both events, ch1 is repeated with it high
    err_evt <= 3'b110;
    ce <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    err_evt <= 3'b010;
    @(posedge clk);
    err_evt <= 3'b000;
    err_code <= 48'h0;
    rdc(1, sps_pkg::REG_FLAGS, 16'hffff, fb(sps_pkg::FB_ERR));
    rdc(1, sps_pkg::REG_ECODE, 16'hffff, 16'h1234);
    rdc(2, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_ERR), 16'h0);
    wr(1, sps_pkg::REG_FLAGS, 16'h0);
    rdc(1, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_ERR), fb(sps_pkg::FB_ERR));
  endtask
  task automatic t_tx;
    wr(1, sps_pkg::REG_FMT, 16'h000e);
    wr(1, sps_pkg::REG_HDR_A, 16'h00a5);
    wr(1, sps_pkg::REG_TRM_A, 16'h000d);
    wr(1, sps_pkg::REG_LEN, 16'h0003);
    slow <= 1'b1;
    wr(1, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_SREQ) | fb(sps_pkg::FB_RCMP));
    rdc(1, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_SREQ), fb(sps_pkg::FB_SREQ));
    wait_sent(6);
    for (int i = 0; i < 6; i++) check({22'h0, far.sent_q[i]}, {22'h0, 2'h1, exp_b[i]});
    far.sent_q.delete();
    slow <= 1'b0;
    rdc(1, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_SREQ), 16'h0);
    rdc(1, sps_pkg::REG_STX, 16'hffff, 16'h0093);
    rdc(1, sps_pkg::REG_REM, 16'hffff, 16'h0000);
  endtask
  task automatic t_dsr;
    dcd <= 3'b110;
    dsr <= 3'b100;
    wr(1, sps_pkg::REG_FMT, 16'h0400);
    wr(1, sps_pkg::REG_LEN, 16'h0001);
    wr(1, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_SREQ) | fb(sps_pkg::FB_RCMP));
    rdc(1, sps_pkg::REG_FLAGS, 16'h0036, 16'h0016);
    check({31'h0, tx_valid[1]}, 32'h0);
    rdc(2, sps_pkg::REG_FLAGS, 16'h0030, 16'h0030);
    rdc(0, sps_pkg::REG_FLAGS, 16'h0030, 16'h0000);
    dsr <= 3'b110;
    wait_sent(1);
    check({22'h0, far.sent_q[0]}, {22'h0, 2'h1, 8'h30});
    far.sent_q.delete();
    rdc(1, sps_pkg::REG_FLAGS, 16'h0022, 16'h0020);
    // Interlink control line holds off the same way
    dsr <= 3'b100;
    wr(1, sps_pkg::REG_FMT, 16'h0800);
    wr(1, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_SREQ));
    rdc(1, sps_pkg::REG_FLAGS, 16'h0006, 16'h0006);
    dsr <= 3'b110;
    wait_sent(1);
    check({22'h0, far.sent_q[0]}, {22'h0, 2'h1, 8'h30});
    far.sent_q.delete();
    dcd <= 3'b000;
    rdc(1, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_CD), 16'h0);
  endtask
  task automatic t_half;
    wr(2, sps_pkg::REG_FMT, 16'h0001);
    wr(2, sps_pkg::REG_LEN, 16'h0301);
    rxb(2, 8'h11);
    wr(2, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_SREQ) | fb(sps_pkg::FB_RCMP));
    rdc(2, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_WAIT), fb(sps_pkg::FB_WAIT));
    check({31'h0, tx_valid[2]}, 32'h0);
    rxb(2, 8'h22);
    rxb(2, 8'h33);
    rdc(2, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_RCMP), fb(sps_pkg::FB_RCMP));
    rdc(2, sps_pkg::REG_RCNT, 16'hffff, 16'h0003);
    wait_sent(1);
    check({22'h0, far.sent_q[0]}, {22'h0, 2'h2, 8'h30});
    rxb(2, 8'h44);
    rdc(2, sps_pkg::REG_RCNT, 16'hffff, 16'h0003);
    wr(2, sps_pkg::REG_FLAGS, 16'h0);
    rdc(2, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_RCMP), 16'h0);
    wr(2, sps_pkg::REG_FMT, 16'h0004);
    wr(2, sps_pkg::REG_TRM_A, 16'h000d);
    wr(2, sps_pkg::REG_LEN, 16'h0800);
    rxb(2, 8'h41);
    rxb(2, 8'h0d);
    rdc(2, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_RCMP), fb(sps_pkg::FB_RCMP));
    // Header gate and received sum: wrong header ignored, sum byte recorded
    wr(2, sps_pkg::REG_FMT, 16'h000a);
    wr(2, sps_pkg::REG_HDR_A, 16'h00a5);
    wr(2, sps_pkg::REG_LEN, 16'h0200);
    wr(2, sps_pkg::REG_FLAGS, 16'h0);
    rxb(2, 8'h5a);
    rxb(2, 8'ha5);
    rxb(2, 8'h10);
    rxb(2, 8'h20);
    rxb(2, 8'h31);
    rdc(2, sps_pkg::REG_FLAGS, fb(sps_pkg::FB_RCMP), fb(sps_pkg::FB_RCMP));
    rdc(2, sps_pkg::REG_RCNT, 16'hffff, 16'h0002);
    rdc(2, sps_pkg::REG_SRX, 16'hffff, 16'h0031);
    rdc(2, sps_pkg::REG_SCAL, 16'hffff, 16'h0030);
  endtask
  task automatic t_tout;
    wr(0, sps_pkg::REG_FMT, 16'h0);
    wr(0, sps_pkg::REG_TO, 16'h0001);
    wr(0, sps_pkg::REG_LEN, 16'h0800);
    rxb(0, 8'h55);
    repeat (3 * TICK) @(posedge clk);
    rdc(0, sps_pkg::REG_FLAGS, 16'h0048, 16'h0048);
    wr(0, sps_pkg::REG_TO, 16'h0000);
    wr(0, sps_pkg::REG_FLAGS, 16'h0);
    rxb(0, 8'h56);
    // Zero setting expires between 9 and 10 units after the byte
    repeat (6 * TICK) @(posedge clk);
    rdc(0, sps_pkg::REG_FLAGS, 16'h0048, 16'h0000);
    repeat (6 * TICK) @(posedge clk);
    rdc(0, sps_pkg::REG_FLAGS, 16'h0048, 16'h0048);
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_err();
    t_tx();
    t_dsr();
    t_half();
    t_tout();
    end_of_test();
  end
endmodule // sps_top_bench
